// File: pkg/ett_pkg.sv
package ett_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [7:0] IDX_SETUP_WORD = 8'h02;
  localparam logic [7:0] IDX_PIN_DIR = 8'h03;
  localparam logic [7:0] ADDR_TIMER_COUNT = {IDX_TIMER_COUNT[5:0], 2'b00};
  localparam logic [7:0] ADDR_SETUP_WORD = {IDX_SETUP_WORD[5:0], 2'b00};
  localparam logic [7:0] ADDR_PIN_DIR = {IDX_PIN_DIR[5:0], 2'b00};

  // Setup word fields
  localparam int unsigned CSS_BIT = 5;
  localparam int unsigned EDGE_BIT = 4;
  localparam int unsigned PSA_BIT = 3;
  localparam int unsigned RATIO_LSB = 0;
  localparam int unsigned RATIO_W = 3;

  localparam logic [7:0] SETUP_RST = 8'hff;
  localparam logic [3:0] PIN_DIR_RST = 4'hf;
  localparam int unsigned EXT_PIN_IDX = 2;

  localparam int unsigned PRESC_W = 8;
  localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

  // Oscillator period equals the clock period here
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TOSC_NS = 20;
  localparam int unsigned PULSE_MIN_TOSC = 2;
  localparam int unsigned PERIOD_MIN_TOSC = 4;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PERIOD_MIN_CYC =
    (PERIOD_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } ett_phase_e;

endpackage : ett_pkg

// File: rtl/ett_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module ett_prescaler #(
  parameter int unsigned WIDTH = ett_pkg::PRESC_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [ett_pkg::RATIO_W-1:0] ratio_i,
  output logic tap_o,
  output logic [WIDTH-1:0] count_o
);
  import ett_pkg::*;

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Clear wins over a step in the same cycle
  always_comb
  begin
    count_nxt = count_r;
    if (clear_i)
    begin
      count_nxt = '0;
    end
    else if (step_i)
    begin
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      count_r <= PRESC_RST;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  // Bit n toggles every 2^n steps, so its rising edge is a 1:2^(n+1) symmetric output
  assign tap_o = count_r[ratio_i];
  assign count_o = count_r;

endmodule : ett_prescaler
`default_nettype wire

// File: rtl/ett_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Timer mode counts each instruction cycle when the prescaler serves the watchdog
// - Count write halts counting two cycles
// - Counter mode counts external input edges
// - Edge select: clear rising, set falling
// - Prescaler serves timer or watchdog, never both
// - Prescaler has no software access
// - Prescale ratios 1:2 through 1:256
// - Count register 8 bits, index 01h
// - Counter mode forces count pin input
// - Sync prescaler output on Q2, Q4
// - Prescaler divides external input symmetrically
// - Increment lags the external edge
// - Count write clears timer prescaler
// - Reset clears the prescaler
// - Shared prescaler is an 8-bit counter
// - Assign bit, ratio in low setup bits
module ett_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_count_input_i,
  input wire logic wdt_tick_i,
  input wire logic wdt_clear_i,
  output logic [3:0] pin_dir_o,
  output logic wdt_post_o
);
  import ett_pkg::*;

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == ADDR_TIMER_COUNT) || (addr == ADDR_SETUP_WORD) ||
                 (addr == ADDR_PIN_DIR);
  endfunction : reg_mapped

  function automatic logic [31:0] reg_read(input logic [7:0] addr,
                                           input logic [7:0] count);
    // Setup and direction words are write-only and read as zero
    reg_read = (addr == ADDR_TIMER_COUNT) ? {24'h000000, count} : 32'h00000000;
  endfunction : reg_read

  // Bus slave
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [7:0] setup_r;
  logic [7:0] setup_nxt;
  logic [3:0] pin_dir_r;
  logic [3:0] pin_dir_nxt;
  logic access;
  logic fire;
  logic wr_count;

  // Phase and synchroniser
  ett_phase_e phase_r;
  ett_phase_e phase_nxt;
  logic sync1_r;
  logic sync2_r;
  logic level_q_r;
  logic samp_r;
  logic samp_nxt;

  // Counting
  logic [7:0] timer_count_r;
  logic [7:0] timer_count_nxt;
  logic [1:0] inhib_r;
  logic [1:0] inhib_nxt;
  logic tap_q_r;
  logic wdt_post_r;
  logic wdt_post_nxt;
  logic [3:0] pin_dir_out_r;
  logic [3:0] pin_dir_out_nxt;

  logic css;
  logic edge_fall;
  logic prescaler_assign;
  logic [RATIO_W-1:0] ratio;
  logic instr_tick;
  logic sample_now;
  logic cnt_level;
  logic level_rise;
  logic presc_step;
  logic presc_clear;
  logic tap;
  logic tap_rise;
  logic pre_out;
  logic ext_inc;
  logic inc_evt;
  logic [PRESC_W-1:0] presc_count;

  assign access = psel_i && penable_i;
  assign fire = access && pready_r;
  assign wr_count = fire && pwrite_i && (paddr_i == ADDR_TIMER_COUNT);

  assign css = setup_r[CSS_BIT];
  assign edge_fall = setup_r[EDGE_BIT];
  assign prescaler_assign = setup_r[PSA_BIT];
  assign ratio = setup_r[RATIO_LSB +: RATIO_W];

  // One wait state: pready rises in the second access cycle
  always_comb
  begin
    pready_nxt = access && !pready_r;
    pslverr_nxt = access && !pready_r && !reg_mapped(paddr_i);
    prdata_nxt = 32'h00000000;
    if (access && !pready_r && !pwrite_i)
    begin
      prdata_nxt = reg_read(paddr_i, timer_count_r);
    end
    setup_nxt = setup_r;
    pin_dir_nxt = pin_dir_r;
    if (fire && pwrite_i && (paddr_i == ADDR_SETUP_WORD))
    begin
      setup_nxt = pwdata_i[7:0];
    end
    if (fire && pwrite_i && (paddr_i == ADDR_PIN_DIR))
    begin
      pin_dir_nxt = pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      setup_r <= SETUP_RST;
      pin_dir_r <= PIN_DIR_RST;
    end
    else
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      setup_r <= setup_nxt;
      pin_dir_r <= pin_dir_nxt;
    end
  end

  // Four phases per instruction cycle
  always_comb
  begin
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
    endcase
  end

  assign instr_tick = (phase_r == PH_Q4);
  assign sample_now = (phase_r == PH_Q2) || (phase_r == PH_Q4);

  // Falling-edge select inverts the level so one rise detector serves both
  assign cnt_level = sync2_r ^ edge_fall;
  assign level_rise = cnt_level && !level_q_r;

  // Prescaler input follows its owner; the ripple chain is modelled synchronously
  assign presc_step = prescaler_assign ? wdt_tick_i : (css ? level_rise : instr_tick);
  assign presc_clear = (wr_count && !prescaler_assign) || (wdt_clear_i && prescaler_assign);

  ett_prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(presc_clear),
    .step_i(presc_step),
    .ratio_i(ratio),
    .tap_o(tap),
    .count_o(presc_count)
  );

  assign tap_rise = tap && !tap_q_r;
  // Without a prescaler the sampled signal is the raw input
  assign pre_out = prescaler_assign ? cnt_level : tap;
  assign samp_nxt = sample_now ? pre_out : samp_r;
  assign ext_inc = sample_now && pre_out && !samp_r;
  assign inc_evt = css ? ext_inc : (prescaler_assign ? instr_tick : tap_rise);

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      phase_r <= PH_Q1;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      // Idle level under the reset edge select, so no false edge follows reset
      level_q_r <= SETUP_RST[EDGE_BIT];
      samp_r <= SETUP_RST[EDGE_BIT];
    end
    else
    begin
      phase_r <= phase_nxt;
      sync1_r <= external_count_input_i;
      sync2_r <= sync1_r;
      level_q_r <= cnt_level;
      samp_r <= samp_nxt;
    end
  end

  always_comb
  begin
    timer_count_nxt = timer_count_r;
    inhib_nxt = inhib_r;
    if (wr_count)
    begin
      timer_count_nxt = pwdata_i[7:0];
      inhib_nxt = INHIBIT_CYCLES;
    end
    else
    begin
      if (inc_evt && (inhib_r == 2'h0))
      begin
        timer_count_nxt = timer_count_r + 8'h01;
      end
      if (instr_tick && (inhib_r != 2'h0))
      begin
        inhib_nxt = inhib_r - 2'h1;
      end
    end
    wdt_post_nxt = prescaler_assign && tap_rise;
    pin_dir_out_nxt = pin_dir_r;
    pin_dir_out_nxt[EXT_PIN_IDX] = pin_dir_r[EXT_PIN_IDX] || css;
  end

  // Count keeps its value through reset; its power-on value is undefined
  always_ff @(posedge ref_clk_i)
  begin
    timer_count_r <= timer_count_nxt;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      inhib_r <= 2'h0;
      tap_q_r <= 1'b0;
      wdt_post_r <= 1'b0;
      pin_dir_out_r <= PIN_DIR_RST;
    end
    else
    begin
      inhib_r <= inhib_nxt;
      tap_q_r <= tap;
      wdt_post_r <= wdt_post_nxt;
      pin_dir_out_r <= pin_dir_out_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign pin_dir_o = pin_dir_out_r;
  assign wdt_post_o = wdt_post_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence count_write_s;
    wr_count;
  endsequence

  sequence count_held_s;
    ($stable(timer_count_r) || $past(wr_count)) [*7];
  endsequence

  property count_steps_p(logic cause);
    (cause && (inhib_r == 2'h0) && !wr_count) |=>
      (timer_count_r == 8'($past(timer_count_r) + 8'h01));
  endproperty

  timer_tick_a: assert property (count_steps_p(!css && prescaler_assign && instr_tick))
    else $error("timer mode missed an instruction-cycle increment");

  write_inhibit_a: assert property (count_write_s |=> ##1 count_held_s)
    else $error("count moved within two instruction cycles of a write");

  write_load_a: assert property (count_write_s |=> (timer_count_r == $past(pwdata_i[7:0])))
    else $error("count write did not load the written value");

  ext_edge_a: assert property (count_steps_p(css && ext_inc))
    else $error("counter mode missed a synchronised edge");

  ext_sample_a: assert property ((css && inc_evt) |-> ((phase_r == PH_Q2) || (phase_r == PH_Q4)))
    else $error("external increment outside a sampling phase");

  presc_tick_a: assert property (count_steps_p(!css && !prescaler_assign && tap_rise))
    else $error("prescaled timer missed an increment");

  psc_clear_a: assert property ((wr_count && !prescaler_assign) |=> (presc_count == PRESC_RST))
    else $error("count write did not clear the prescaler");

  psc_reset_a: assert property (disable iff (1'b0) rst_i |=> (presc_count == PRESC_RST))
    else $error("reset did not clear the prescaler");

  wdt_owner_a: assert property (wdt_post_r |-> $past(prescaler_assign))
    else $error("watchdog output while prescaler belongs to timer");

  pin_force_a: assert property (css |=> pin_dir_o[EXT_PIN_IDX])
    else $error("count pin not forced to input in counter mode");

  rd_count_a: assert property ((fire && !pwrite_i && (paddr_i == ADDR_TIMER_COUNT)) |->
      (prdata_o == {24'h000000, $past(timer_count_r)}))
    else $error("count read returned a stale value");

  count_wrap_a: assert property ((inc_evt && (inhib_r == 2'h0) && !wr_count &&
      (timer_count_r == 8'hff)) |=> (timer_count_r == 8'h00))
    else $error("count did not wrap to zero");

  presc_hold_a: assert property ((prescaler_assign && !wdt_tick_i && !wdt_clear_i) |=> $stable(presc_count))
    else $error("watchdog-owned prescaler moved without a watchdog tick");

  pready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready stood longer than one cycle");

  unmapped_wr_a: assert property ((access && !pready_r && pwrite_i && !reg_mapped(paddr_i)) |=>
      ##1 ($stable(setup_r) && $stable(pin_dir_r)))
    else $error("write to an unmapped address changed a register");

  // Raw pin path only; the prescaled path adds its own division
  sequence ext_rise_s;
    css && prescaler_assign && !edge_fall && (inhib_r == 2'h0) && !wr_count && $rose(sync2_r);
  endsequence

  ext_delay_a: assert property (ext_rise_s |-> ##[1:2] $changed(timer_count_r))
    else $error("synchronised edge not counted within the sampling delay");

endmodule : ett_timer
`default_nettype wire

// File: test/ett_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module ett_ext_src (
  input wire logic ref_clk_i,
  output logic pin_o
);
  import ett_pkg::*;

  initial pin_o = 1'b0;

  // Narrower levels would be lost by the phase sampler
  task toggles(input int n, input int w);
    int hold;
    begin
      hold = (w < PULSE_MIN_CYC) ? PULSE_MIN_CYC : w;
      repeat (n)
      begin
        @(posedge ref_clk_i);
        pin_o <= ~pin_o;
        repeat (hold - 1) @(posedge ref_clk_i);
      end
    end
  endtask : toggles
endmodule : ett_ext_src
`default_nettype wire

// File: test/ett_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ett_timer_tb;
  import ett_pkg::*;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic tick = 0;
  logic wclr = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [31:0] q0;
  logic pready;
  logic pslverr;
  logic pin;
  logic wpost;
  logic e;
  logic [3:0] pdir;
  int miscompares = 0;
  int comparisons = 0;
  int posts = 0;
  int p0;

  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (wpost === 1'b1) posts <= posts + 1;

  ett_timer i_ett_timer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .external_count_input_i(pin), .wdt_tick_i(tick), .wdt_clear_i(wclr),
    .pin_dir_o(pdir), .wdt_post_o(wpost));
  ett_ext_src i_ett_ext_src (.ref_clk_i(ref_clk_i), .pin_o(pin));

  task results();
    $display("checks %0d errors %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge ref_clk_i);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      pen <= 1;
      n = 0;
      do
      begin
        @(posedge ref_clk_i);
        n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
      if (n >= 20)
      begin
        miscompares++;
        results();
      end
    end
  endtask : apb

  task idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle

  task ticks(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      tick <= 1;
      @(posedge ref_clk_i);
      tick <= 0;
    end
  endtask : ticks

  // Each count check starts from a fresh write, past the inhibit
  task ext_run(input logic [7:0] setup, input int n, input logic [31:0] exp);
    apb(1, ADDR_SETUP_WORD, setup);
    apb(1, ADDR_TIMER_COUNT, 0);
    idle(12);
    i_ett_ext_src.toggles(n, 3);
    idle(12);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("ext_count", q, exp);
  endtask : ext_run

  initial
  begin
    idle(10);
    rst_i <= 0;
    idle(1);
    check("pin_dir_rst", pdir, 4'hf);
    // Count powers up unknown; give it a value before any mode can count
    apb(1, ADDR_TIMER_COUNT, 0);
    apb(0, ADDR_SETUP_WORD, 0);
    check("setup_wo", q, 0);
    apb(0, 8'h40, 0);
    check("unmapped_err", e, 1);
    check("unmapped_data", q, 0);
    apb(1, 8'h40, 0);
    check("unmapped_wr_err", e, 1);
    apb(1, ADDR_PIN_DIR, 0);
    apb(1, ADDR_SETUP_WORD, 8'h08);
    idle(2);
    check("pin_dir_timer", pdir, 4'h0);
    apb(1, ADDR_TIMER_COUNT, 8'hff);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("inhibit", q, 8'hff);
    idle(7);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("wrap", q[31:1], 0);
    q0 = q;
    idle(36);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("timer_rate", q - q0, 10);
    @(posedge ref_clk_i);
    wclr <= 1;
    @(posedge ref_clk_i);
    wclr <= 0;
    p0 = posts;
    ticks(8);
    idle(4);
    check("wdt_post", posts - p0, 4);
    for (int n = 0; n < 8; n++)
    begin
      apb(1, ADDR_SETUP_WORD, n);
      idle(4);
      apb(0, ADDR_TIMER_COUNT, 0);
      q0 = q;
      idle((16 << n) - 4);
      apb(0, ADDR_TIMER_COUNT, 0);
      check("ratio", q - q0, 2);
    end
    p0 = posts;
    ticks(8);
    idle(4);
    check("wdt_no_post", posts - p0, 0);
    // Cleared 1:256 prescaler gives its first rise after half the ratio
    apb(1, ADDR_TIMER_COUNT, 8'h40);
    idle(480);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("presc_clear", q, 8'h40);
    idle(32);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("presc_first", q, 8'h41);
    apb(1, ADDR_SETUP_WORD, 8'h28);
    idle(2);
    check("pin_dir_ctr", pdir, 4'h4);
    ext_run(8'h28, 5, 3);
    ext_run(8'h38, 5, 3);
    ext_run(8'h21, 16, 2);
    // Edge select must already be falling, as reset sets it
    apb(1, ADDR_SETUP_WORD, 8'h38);
    apb(1, ADDR_TIMER_COUNT, 8'h5a);
    idle(2);
    rst_i <= 1;
    idle(3);
    rst_i <= 0;
    idle(1);
    check("pin_dir_rst2", pdir, 4'hf);
    apb(0, ADDR_TIMER_COUNT, 0);
    check("count_kept", q, 8'h5a);
    results();
  end
endmodule : ett_timer_tb
`default_nettype wire
